// *** hw/nfcd_cfg.svh ***
`ifndef NFCD_CFG_SVH
`define NFCD_CFG_SVH
// unlock and command addresses, word width
`define NFCD_W_UNLK1   12'h555
`define NFCD_W_UNLK2   12'h2AA
`define NFCD_W_CFI     12'h055
// unlock and command addresses, byte width
`define NFCD_B_UNLK1   12'hAAA
`define NFCD_B_UNLK2   12'h555
`define NFCD_B_CFI     12'h0AA
// id offsets
`define NFCD_W_MAKER   12'h000
`define NFCD_W_DEVID   12'h001
`define NFCD_W_PROT    12'h002
`define NFCD_B_MAKER   12'h000
`define NFCD_B_DEVID   12'h002
`define NFCD_B_PROT    12'h004
// command data values
`define NFCD_D_UNLK1   8'hAA
`define NFCD_D_UNLK2   8'h55
`define NFCD_D_RESET   8'hF0
`define NFCD_D_PROG    8'hA0
`define NFCD_D_ESETUP  8'h80
`define NFCD_D_CHIP    8'h10
`define NFCD_D_SECT    8'h30
`define NFCD_D_SUSP    8'hB0
`define NFCD_D_RESUME  8'h30
`define NFCD_D_CFI     8'h98
`define NFCD_D_AUTO    8'h90
`define NFCD_D_OTP     8'h88
`define NFCD_D_OTPX    8'h00
// bus cycles per command sequence
`define NFCD_N_SINGLE  3'h1
`define NFCD_N_PROG    3'h4
`define NFCD_N_ERASE   3'h6
`define NFCD_N_AUTOID  3'h4
`define NFCD_N_OTPX    3'h4
`define NFCD_N_OTPE    3'h3
// sector field position within the address
`define NFCD_SECT_LSB  12
// bus timing, each phase lasting one clock more than its value: setup, strobe low, hold
`define NFCD_T_SETUP   3'h2
`define NFCD_T_PULSE   3'h6
`define NFCD_T_HOLD    3'h2
`endif

// *** hw/nfcd_pkg.sv ***
package nfcd_pkg;
	// operation requested of the flash
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_AUTOID, OP_PROG, OP_CHIPERASE, OP_SECTERASE,
		OP_SUSPEND, OP_RESUME, OP_CFI, OP_OTPENTER, OP_OTPEXIT
	} nfcd_op_t;
	// one bus cycle toward the flash
	typedef struct packed {
		logic        isRead;
		logic [21:0] addr;
		logic [15:0] data;
	} nfcd_cyc_t;
	// host-side request
	typedef struct packed {
		nfcd_op_t    op;
		logic [21:0] addr;
		logic [15:0] data;
	} nfcd_req_t;
endpackage

// *** hw/nfcd_seq_rom.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nfcd_cfg.svh"
// step table: returns one bus cycle of a command sequence, registered
module nfcd_seq_rom
	import nfcd_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// lookup
	input  wire nfcd_op_t    op,
	input  wire logic [2:0]  step,
	input  wire logic        byteMode,
	input  wire logic [21:0] userAddr,
	input  wire logic [15:0] userData,
	// result
	output nfcd_cyc_t        cycOut,
	output logic      [2:0]  cycCount
);
	logic [11:0] aU1;        // first unlock address
	logic [11:0] aU2;        // second unlock address
	nfcd_cyc_t   cycD;       // combinational step
	logic [2:0]  cntD;       // cycles of this op

	assign aU1 = byteMode ? `NFCD_B_UNLK1 : `NFCD_W_UNLK1;
	assign aU2 = byteMode ? `NFCD_B_UNLK2 : `NFCD_W_UNLK2;

	// --------------------------------------------------------
	// step decode
	// --------------------------------------------------------
	always_comb begin
		cycD = '0;
		cntD = `NFCD_N_SINGLE;
		case (op)
			OP_READ: begin
				cycD = {1'b1, userAddr, 16'h0000};
			end
			OP_RESET, OP_SUSPEND, OP_RESUME: begin
				cycD = {1'b0, userAddr, 8'h00,
					(op == OP_RESET) ? `NFCD_D_RESET :
					(op == OP_SUSPEND) ? `NFCD_D_SUSP : `NFCD_D_RESUME};
			end
			OP_CFI: begin
				cycD = {1'b0, 10'h000, byteMode ? `NFCD_B_CFI : `NFCD_W_CFI,
					8'h00, `NFCD_D_CFI};
			end
			default: begin
				case (op)
					OP_PROG: cntD = `NFCD_N_PROG;
					OP_CHIPERASE, OP_SECTERASE: cntD = `NFCD_N_ERASE;
					OP_OTPEXIT: cntD = `NFCD_N_OTPX;
					OP_AUTOID: cntD = `NFCD_N_AUTOID;
					default: cntD = `NFCD_N_OTPE;
				endcase
				case (step)
					3'h0: cycD = {1'b0, 10'h000, aU1, 8'h00, `NFCD_D_UNLK1};
					3'h1: cycD = {1'b0, 10'h000, aU2, 8'h00, `NFCD_D_UNLK2};
					3'h2: begin
						cycD = {1'b0, 10'h000, aU1, 8'h00, `NFCD_D_AUTO};
						if (op == OP_PROG) cycD.data = {8'h00, `NFCD_D_PROG};
						if (op == OP_CHIPERASE || op == OP_SECTERASE)
							cycD.data = {8'h00, `NFCD_D_ESETUP};
						if (op == OP_OTPENTER) cycD.data = {8'h00, `NFCD_D_OTP};
					end
					3'h3: begin
						if (op == OP_PROG) cycD = {1'b0, userAddr, userData};
						else if (op == OP_OTPEXIT)
							cycD = {1'b0, userAddr, 8'h00, `NFCD_D_OTPX};
						else if (op == OP_AUTOID) cycD = {1'b1, userAddr, 16'h0000};
						else cycD = {1'b0, 10'h000, aU1, 8'h00, `NFCD_D_UNLK1};
					end
					3'h4: cycD = {1'b0, 10'h000, aU2, 8'h00, `NFCD_D_UNLK2};
					default: begin
						if (op == OP_SECTERASE)
							cycD = {1'b0, userAddr, 8'h00, `NFCD_D_SECT};
						else cycD = {1'b0, 10'h000, aU1, 8'h00, `NFCD_D_CHIP};
					end
				endcase
			end
		endcase
	end

	// --------------------------------------------------------
	// registered output
	// --------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cycOut   <= '0;
			cycCount <= `NFCD_N_SINGLE;
		end else begin
			cycOut   <= cycD;
			cycCount <= cntD;
		end
	end
endmodule // nfcd_seq_rom
`default_nettype wire

// *** hw/nfcd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "nfcd_cfg.svh"
// Contract
// - all steps write except read steps
// - F0 anywhere resets to read
// - unlock AA/55 at width-mapped addresses
// - program is four writes, data last
// - chip erase is six writes
// - sector erase sixth write 30 at sector
// - B0 anywhere suspends sector erase
// - 30 anywhere resumes sector erase
// - 98 at 55/AA enters cfi query
// - otp entry is three writes 88
// - otp exit unlock, 90, then 00
// - write is cs and we low, oe high
// - id mode held until reset written
module nfcd_host
	import nfcd_pkg::*;
#(
	parameter int ADDR_W = 22   // flash address width
)
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// user request
	input  wire logic        reqValid,
	input  wire nfcd_req_t   req,
	input  wire logic        byteMode,
	output logic             reqReady,
	// user answer
	output logic             rspValid,
	output logic [15:0]      rspData,
	output logic             eraseRunning,
	output logic             idMode,
	// flash pins
	output logic [21:0]      flashAddr,
	output logic [15:0]      flashDqOut,
	output logic             flashDqOe,
	input  wire logic [15:0] flashDqIn,
	output logic             flashCsN,
	output logic             flashWeN,
	output logic             flashOeN,
	output logic             flashByteN
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_LOOK, S_SETUP, S_PULSE, S_HOLD} nfcd_st_t;
	nfcd_st_t    st_q;           // sequencer state
	nfcd_req_t   req_q;          // captured request
	logic        byte_q;         // width latched with request
	logic [2:0]  step_q;         // cycle index in sequence
	logic [2:0]  tmr_q;          // phase timer
	nfcd_cyc_t   cyc;            // current cycle from table
	logic [2:0]  cycCount;       // cycles in current op
	logic [15:0] dqS1_q;         // synchroniser stage one
	logic [15:0] dqS2_q;         // synchroniser stage two
	logic        suspended_q;    // erase is suspended
	logic        okToIssue;      // command allowed now

	nfcd_seq_rom u_rom (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.op       (req_q.op),
		.step     (step_q),
		.byteMode (byte_q),
		.userAddr (req_q.addr),
		.userData (req_q.data),
		.cycOut   (cyc),
		.cycCount (cycCount)
	);

	// ------------------------------------------------------------
	// data input synchroniser
	// ------------------------------------------------------------
	// the pins are asynchronous; two flops before the answer reads them
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dqS1_q <= '0;
			dqS2_q <= '0;
		end else begin
			dqS1_q <= flashDqIn;
			dqS2_q <= dqS1_q;
		end
	end

	// hold off all but suspend while erasing
	// id mode blocks all but reset and autoid until reset issued
	always_comb begin
		okToIssue = 1'b1;
		if (eraseRunning && !suspended_q)
			okToIssue = (req.op == OP_SUSPEND);
		else if (idMode)
			okToIssue = (req.op == OP_RESET) || (req.op == OP_AUTOID);
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// every cycle has setup, strobe-low and hold phases so that the
	// address is stable before the fall and data before the rise
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st_q   <= S_IDLE;
			req_q  <= '0;
			byte_q <= 1'b0;
			step_q <= 3'h0;
			tmr_q  <= 3'h0;
		end else begin
			case (st_q)
				S_IDLE: begin
					if (reqValid && reqReady && okToIssue) begin
						req_q  <= req;
						byte_q <= byteMode;
						step_q <= 3'h0;
						st_q   <= S_LOOK;
					end
				end
				S_LOOK: begin
					// table output is registered; one cycle to settle
					tmr_q <= `NFCD_T_SETUP;
					st_q  <= S_SETUP;
				end
				S_SETUP: begin
					if (tmr_q == 3'h0) begin
						tmr_q <= `NFCD_T_PULSE;
						st_q  <= S_PULSE;
					end else begin
						tmr_q <= tmr_q - 3'h1;
					end
				end
				S_PULSE: begin
					if (tmr_q == 3'h0) begin
						tmr_q <= `NFCD_T_HOLD;
						st_q  <= S_HOLD;
					end else begin
						tmr_q <= tmr_q - 3'h1;
					end
				end
				S_HOLD: begin
					if (tmr_q != 3'h0) begin
						tmr_q <= tmr_q - 3'h1;
					end else if (step_q + 3'h1 < cycCount) begin
						step_q <= step_q + 3'h1;
						st_q   <= S_LOOK;
					end else begin
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			flashAddr  <= '0;
			flashDqOut <= '0;
			flashDqOe  <= 1'b0;
			flashCsN   <= 1'b1;
			flashWeN   <= 1'b1;
			flashOeN   <= 1'b1;
			flashByteN <= 1'b1;
		end else begin
			flashByteN <= ~byte_q;
			if (st_q == S_SETUP || st_q == S_PULSE || st_q == S_HOLD) begin
				// high unlock bits held at zero
				// sector bits pass from user address
				flashAddr  <= cyc.addr[ADDR_W-1:0];
				flashDqOut <= cyc.data;
				// drive data only on write steps
				flashDqOe  <= ~cyc.isRead;
			end else begin
				flashDqOe  <= 1'b0;
			end
			// cs and we low, oe high on writes; cs and oe low, we high on reads
			// strobes bracket stable address and data
			flashCsN <= ~(st_q == S_PULSE);
			flashWeN <= ~(st_q == S_PULSE && !cyc.isRead);
			flashOeN <= ~(st_q == S_PULSE && cyc.isRead);
		end
	end

	// ------------------------------------------------------------
	// answer and mode tracking
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			reqReady     <= 1'b0;
			rspValid     <= 1'b0;
			rspData      <= '0;
			eraseRunning <= 1'b0;
			suspended_q  <= 1'b0;
			idMode       <= 1'b0;
		end else begin
			reqReady <= (st_q == S_IDLE) && !(reqValid && reqReady);
			rspValid <= 1'b0;
			// read data sampled after pulse, via synchroniser
			if (st_q == S_HOLD && tmr_q == 3'h0 && cyc.isRead) begin
				rspValid <= 1'b1;
				rspData  <= dqS2_q;
			end
			if (st_q == S_HOLD && tmr_q == 3'h0 && step_q + 3'h1 >= cycCount) begin
				case (req_q.op)
					OP_SUSPEND: suspended_q <= eraseRunning;
					OP_RESUME: suspended_q <= 1'b0;
					OP_SECTERASE: eraseRunning <= 1'b1;
					OP_AUTOID: idMode <= 1'b1;
					OP_RESET: begin
						idMode       <= 1'b0;
						eraseRunning <= 1'b0;
						suspended_q  <= 1'b0;
					end
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_write_strobes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!flashWeN |-> (!flashCsN && flashOeN))
		else $error("write strobe without cs or with oe");
	a_addr_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(flashCsN) |-> $stable(flashAddr))
		else $error("address moved at strobe fall");
	a_data_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(flashWeN) |-> $stable(flashDqOut) && flashDqOe)
		else $error("data moved at strobe rise");
	a_erase_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_IDLE && eraseRunning && !suspended_q && reqValid && reqReady
			&& req.op != OP_SUSPEND) |=> st_q == S_IDLE)
		else $error("command issued during erase");
	a_unlock_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h0 && cycCount > 3'h1)
			|-> flashDqOut[7:0] == `NFCD_D_UNLK1)
		else $error("first unlock data wrong");
	a_unlock_second: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h1) |-> flashDqOut[7:0] == `NFCD_D_UNLK2)
		else $error("second unlock data wrong");
	a_prog_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h3 && req_q.op == OP_PROG)
			|-> flashDqOut == req_q.data)
		else $error("program data wrong");
	a_id_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(idMode && !(st_q == S_HOLD && req_q.op == OP_RESET)) |=> idMode)
		else $error("id mode left without reset");

	// ------------------------------------------------------------
	// strobe shape and command word checks
	// ------------------------------------------------------------
	// all three strobes low reads as a read on the flash side, so the
	// host must never drive the data lines while the output strobe is low
	a_read_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!flashOeN |-> (!flashDqOe && flashWeN && !flashCsN))
		else $error("data driven during a read strobe");
	// the strobe stays low the full pulse, then rises once
	a_cs_width: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(flashCsN) |-> (!flashCsN) [*7] ##1 flashCsN)
		else $error("chip select pulse has the wrong length");
	// nothing on the bus moves while the strobe is low
	a_bus_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!flashCsN |-> ($stable(flashAddr) && $stable(flashDqOut)))
		else $error("bus moved while strobe low");
	a_cfi_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && req_q.op == OP_CFI) |-> (flashDqOut[7:0] == `NFCD_D_CFI
			&& flashAddr[11:0] == (flashByteN ? `NFCD_W_CFI : `NFCD_B_CFI)))
		else $error("query entry write wrong");
	a_reset_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && req_q.op == OP_RESET) |-> flashDqOut[7:0] == `NFCD_D_RESET)
		else $error("reset command data wrong");
	a_suspend_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && req_q.op == OP_SUSPEND) |-> flashDqOut[7:0] == `NFCD_D_SUSP)
		else $error("suspend command data wrong");
	a_resume_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && req_q.op == OP_RESUME) |-> flashDqOut[7:0] == `NFCD_D_RESUME)
		else $error("resume command data wrong");
	a_prog_setup: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h2 && req_q.op == OP_PROG)
			|-> flashDqOut[7:0] == `NFCD_D_PROG)
		else $error("program setup data wrong");
	a_otp_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h2 && req_q.op == OP_OTPENTER)
			|-> flashDqOut[7:0] == `NFCD_D_OTP)
		else $error("otp entry data wrong");
	a_otp_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h3 && req_q.op == OP_OTPEXIT)
			|-> flashDqOut[7:0] == `NFCD_D_OTPX)
		else $error("otp exit data wrong");
	a_chip_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h5 && req_q.op == OP_CHIPERASE)
			|-> (flashDqOut[7:0] == `NFCD_D_CHIP
			&& flashAddr[11:0] == (flashByteN ? `NFCD_W_UNLK1 : `NFCD_B_UNLK1)))
		else $error("chip erase final write wrong");
	a_sect_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(st_q == S_PULSE && step_q == 3'h5 && req_q.op == OP_SECTERASE)
			|-> (flashDqOut[7:0] == `NFCD_D_SECT && flashAddr == req_q.addr))
		else $error("sector erase final write wrong");
endmodule // nfcd_host
`default_nettype wire

// *** dv/nfcd_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// behavioural flash device on the far side of the sequencer
module nfcd_flash_model
	import nfcd_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
	parameter logic [15:0] DEV_ID   = 16'h5A3C  // arbitrary value
)
(
	// flash pins
	input  wire logic [21:0] flashAddr,
	input  wire logic [15:0] flashDqOut,
	input  wire logic        flashDqOe,
	output logic      [15:0] flashDqIn,
	input  wire logic        flashCsN,
	input  wire logic        flashWeN,
	input  wire logic        flashOeN,
	input  wire logic        flashByteN,
	// last decoded operation, for the bench
	output var nfcd_op_t     lastOp
);
	logic [15:0] memA [int];     // main array, unwritten and chip-erased cells absent
	logic [15:0] memO [int];     // one-time-programmable region
	logic [21:0] aLat;           // address of the write under way
	logic [15:0] rel = 16'hC3C3; // released bus never shows old data
	logic        inWr = 0;
	logic        idm = 0;
	logic        otp = 0;
	logic        ers = 0;
	logic        susp = 0;
	int          st = 0;         // command step reached
	initial lastOp = OP_READ;
	function automatic logic [15:0] rd(logic [21:0] a);
		logic [7:0] o;
		o = flashByteN ? a[7:0] : a[8:1];
		if (idm)
			return (o == 8'h00) ? MAKER_ID : (o == 8'h01) ? DEV_ID : {15'h0, a[12]};
		if (otp)
			return memO.exists(a) ? memO[a] : 16'hFFFF;
		return memA.exists(a) ? memA[a] : 16'hFFFF;
	endfunction
	// command decode, mismatch drops to read
	task automatic wr(logic [21:0] a, logic [15:0] d);
		logic u1;
		logic u2;
		int   nx;
		u1 = flashByteN ? (a[10:0] == 11'h555) : (a[11:0] == 12'hAAA);
		u2 = flashByteN ? (a[10:0] == 11'h2AA) : (a[11:0] == 12'h555);
		nx = 0;
		if (ers) begin
			if (d[7:0] == 8'hB0) begin
				ers = 0;
				susp = 1;
				lastOp = OP_SUSPEND;
			end
		end else if (d[7:0] == 8'hF0) begin
			idm = 0;
			susp = 0;
			lastOp = OP_RESET;
		end else if (st == 0 && susp && d[7:0] == 8'h30) begin
			ers = 1;
			susp = 0;
			lastOp = OP_RESUME;
		end else case (st)
			0: if (d[7:0] == 8'hAA && u1) nx = 1;
				else if (d[7:0] == 8'h98 && a[7:0] == (flashByteN ? 8'h55 : 8'hAA)) lastOp = OP_CFI;
			1: if (d[7:0] == 8'h55 && u2) nx = 2;
			2: if (u1) case (d[7:0])
				8'hA0: nx = 3;
				8'h80: nx = 4;
				8'h88: begin
					otp = 1;
					lastOp = OP_OTPENTER;
				end
				8'h90: if (otp) nx = 7;
					else begin
						idm = 1;
						lastOp = OP_AUTOID;
					end
				default: nx = 0;
			endcase
			3: begin
				if (otp) memO[a] = d;
				else memA[a] = d;
				lastOp = OP_PROG;
			end
			4: if (d[7:0] == 8'hAA && u1) nx = 5;
			5: if (d[7:0] == 8'h55 && u2) nx = 6;
			// erase whole array or one sector
			6: if (d[7:0] == 8'h10 && u1) begin
					memA.delete();
					lastOp = OP_CHIPERASE;
				end else if (d[7:0] == 8'h30) begin
					foreach (memA[k]) if (k[20:12] == a[20:12]) memA[k] = 16'hFFFF;
					ers = 1;
					lastOp = OP_SECTERASE;
				end
			7: if (d[7:0] == 8'h00) begin
					otp = 0;
					lastOp = OP_OTPEXIT;
				end
			default: nx = 0;
		endcase
		st = nx;
	endtask
	// address at the later fall, output strobe high
	always @(negedge flashCsN or negedge flashWeN)
		if (!flashCsN && !flashWeN && flashOeN) begin
			aLat = flashAddr;
			inWr = 1;
		end
	always @(posedge flashCsN or posedge flashWeN)
		if (inWr) begin
			inWr = 0;
			// an undriven bus floats: the model then takes a wrong word
			wr(aLat, flashDqOe ? flashDqOut : ~flashDqOut);
		end
	// drive only while selected and output enabled
	always @*
		flashDqIn = (!flashCsN && !flashOeN) ? rd(flashAddr) : rel;
	always @(posedge flashOeN) rel = ~rd(flashAddr);
endmodule // nfcd_flash_model
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import nfcd_pkg::*;
;
	localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
	localparam logic [15:0] DEVC  = 16'h5A3C; // arbitrary value
	logic        ref_clk;
	logic        rst_n;
	logic        reqValid;
	logic        byteMode;
	nfcd_req_t   req;
	logic        reqReady, rspValid, eraseRunning, idMode, flashDqOe;
	logic        flashCsN, flashWeN, flashOeN, flashByteN;
	logic [15:0] rspData, flashDqOut, flashDqIn;
	logic [21:0] flashAddr;
	nfcd_op_t    lastOp;
	logic [15:0] expQ [$]; // read data still owed by the design
	int          bad_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          seed = 54979;
	always #4 ref_clk = ~ref_clk;
	nfcd_host dut (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.reqValid     (reqValid),
		.req          (req),
		.byteMode     (byteMode),
		.reqReady     (reqReady),
		.rspValid     (rspValid),
		.rspData      (rspData),
		.eraseRunning (eraseRunning),
		.idMode       (idMode),
		.flashAddr    (flashAddr),
		.flashDqOut   (flashDqOut),
		.flashDqOe    (flashDqOe),
		.flashDqIn    (flashDqIn),
		.flashCsN     (flashCsN),
		.flashWeN     (flashWeN),
		.flashOeN     (flashOeN),
		.flashByteN   (flashByteN)
	);
	nfcd_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEVC)) flash (
		.flashAddr    (flashAddr),
		.flashDqOut   (flashDqOut),
		.flashDqOe    (flashDqOe),
		.flashDqIn    (flashDqIn),
		.flashCsN     (flashCsN),
		.flashWeN     (flashWeN),
		.flashOeN     (flashOeN),
		.flashByteN   (flashByteN),
		.lastOp       (lastOp)
	);
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// hang guard, far above the expected run length
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	// compare each returned read with the oldest note
	always @(posedge ref_clk)
		if (rspValid === 1'b1) begin
			if (expQ.size() == 0) chk("spareRsp", 16'h1, 16'h0);
			else chk("rspData", rspData, expQ.pop_front());
		end
	// one request; a refused one is held a while and must leave the flash alone
	task automatic run(nfcd_op_t op, logic [21:0] a, logic [15:0] d, bit take = 1);
		nfcd_op_t was;
		int       n;
		was = lastOp;
		n = 0;
		@(posedge ref_clk);
		#1;
		req = '{op, a, d};
		reqValid = 1;
		while (reqReady !== 1'b1 && n < 400) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		repeat (take ? 1 : 6) @(posedge ref_clk);
		#1;
		reqValid = 0;
		repeat (4) if (reqReady === 1'b1) @(posedge ref_clk);
		#1;
		while (reqReady !== 1'b1 && n < 800) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk("readyWait", 16'(n < 800), 16'h1);
		if (op != OP_READ) chk("flashOp", lastOp, take ? op : was);
	endtask
	initial begin
		logic [21:0] a;
		logic [15:0] d;
		logic [11:0] off [4];
		ref_clk = 1'h0;
		rst_n = 1'h0;
		reqValid = 1'h0;
		byteMode = 1'h0;
		req = '0;
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1;
		repeat (4) begin
			a = 22'($random(seed));
			d = 16'($random(seed));
			run(OP_PROG, a, d);
			expQ.push_back(d);
			run(OP_READ, a, 16'h0);
		end
		a = 22'h012345;
		run(OP_PROG, a, 16'h1234);
		run(OP_PROG, a ^ 22'h001000, 16'h5678);
		run(OP_SECTERASE, a, 16'h0);
		chk("eraseOn", {15'h0, eraseRunning}, 16'h1);
		run(OP_PROG, a, 16'h0, 0);
		run(OP_SUSPEND, 22'h3FFFFF, 16'h0);
		run(OP_RESUME, 22'h2AAAAA, 16'h0);
		run(OP_SUSPEND, 22'h0, 16'h0);
		run(OP_RESET, 22'h155555, 16'h0);
		chk("eraseOff", {15'h0, eraseRunning}, 16'h0);
		expQ.push_back(16'hFFFF);
		run(OP_READ, a, 16'h0);
		expQ.push_back(16'h5678);
		run(OP_READ, a ^ 22'h001000, 16'h0);
		run(OP_CHIPERASE, 22'h0, 16'h0);
		expQ.push_back(16'hFFFF);
		run(OP_READ, a ^ 22'h001000, 16'h0);
		run(OP_OTPENTER, 22'h0, 16'h0);
		run(OP_PROG, a, 16'h005A);
		expQ.push_back(16'h005A);
		run(OP_READ, a, 16'h0);
		run(OP_OTPEXIT, 22'h0, 16'h0);
		expQ.push_back(16'hFFFF);
		run(OP_READ, a, 16'h0);
		for (int b = 0; b < 2; b++) begin
			byteMode = b[0];
			run(OP_CFI, 22'h0, 16'h0);
			run(OP_RESET, 22'h0, 16'h0);
			off = b ? '{12'h000, 12'h200, 12'h002, 12'h004} : '{12'h000, 12'h100, 12'h001, 12'h002};
			for (int k = 0; k < 4; k++) begin
				expQ.push_back(k < 2 ? MAKER : k == 2 ? DEVC : 16'h0001);
				run(OP_AUTOID, (k == 3 ? 22'h013000 : 22'h0) | 22'(off[k]), 16'h0);
			end
			chk("idOn", {15'h0, idMode}, 16'h1);
			run(OP_PROG, a, 16'h0, 0);
			run(OP_RESET, 22'h0, 16'h0);
			chk("idOff", {15'h0, idMode}, 16'h0);
			expQ.push_back(16'hFFFF);
			run(OP_READ, a, 16'h0);
		end
		repeat (20) @(posedge ref_clk);
		chk("owedReads", 16'(expQ.size()), 16'h0);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
